// [hdl/dswbd_decoder.sv]
// Data space window and bank decoder top level
// How it works
// [R1] 40h-7Fh reads a read-only program ROM window
// [R2] ROM address is window register above offset
// [R3] Window register at C9h, write-only, 64-byte steps
// [R4] Window never reaches above lowest 16k ROM
// [R5] Window register eight bits, undefined after reset
// [R6] 80h-BFh always hits static data RAM
// [R7] 00h-3Fh goes to bank chosen at E8h
// [R8] Codes 01-03h, 81-83h pick EEPROM pages 0-5
// [R9] Codes 20h, 40h pick display pages 5, 6
// [R10] Codes 04h, 08h, 10h pick RAM pages 2-4
// [R11] Software sets only one bank at once
// [R12] Software keeps RAM copy of bank select
// [R13] Software keeps RAM copy of window register
// [R14] Unlisted bank code: reads undefined, writes dropped
//
// Implementation choice: the plain strobed port.
module dswbd_decoder
	import dswbd_pkg::*;
(
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic ce_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic [ROM_ADDR_BITS-1:0] rom_addr_out,
	output logic rom_rd_out,
	input wire logic [7:0] rom_data_in,
	output logic [5:0] bank_addr_out,
	output logic [7:0] bank_wdata_out,
	output logic [2:0] bank_page_out,
	output logic eeprom_rd_out,
	output logic eeprom_wr_out,
	output logic bank_ram_rd_out,
	output logic bank_ram_wr_out,
	output logic display_rd_out,
	output logic display_wr_out,
	input wire logic [7:0] eeprom_data_in,
	input wire logic [7:0] bank_ram_data_in,
	input wire logic [7:0] display_data_in,
	output logic [7:0] rom_window_select_out,
	output logic [7:0] data_bank_select_out
);
	logic [7:0] rom_window_select;
	logic [7:0] data_bank_select;
	logic [1:0] region;
	logic [1:0] rd_region;
	dswbd_target_e rd_target;
	logic [7:0] ram_rdata;
	logic bank_access;
	logic ram_access;
	dswbd_bank_if bank ();

	dswbd_bank_decode u_bank_decode (
		.bank(bank)
	);
	assign bank.code = data_bank_select;

	// Region taken from the two top address bits
	assign region = addr_in[7:6];
	assign bank_access = (region == REGION_BANK) && ce_in; // [R7]
	assign ram_access = (region == REGION_RAM) && ce_in; // [R6]

	dswbd_static_ram u_static_ram (
		.mclk_in(mclk_in),
		.ce_in(ram_access && (rd_in || wr_in)),
		.wr_in(wr_in),
		.addr_in(addr_in[OFFSET_BITS-1:0]),
		.wdata_in(wdata_in),
		.rdata_out(ram_rdata)
	);

	// Window register; reset to zero although software may not rely on it
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rom_window_select <= REG_RESET; // [R5]
		end else if (ce_in && wr_in && addr_in == ADDR_ROM_WINDOW_SELECT) begin
			rom_window_select <= wdata_in; // [R3]
		end
	end

	// Bank select register; reset value is a no-bank code
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			data_bank_select <= REG_RESET; // [R14]
		end else if (ce_in && wr_in && addr_in == ADDR_DATA_BANK_SELECT) begin
			data_bank_select <= wdata_in; // [R7]
		end
	end

	assign rom_window_select_out = rom_window_select;
	assign data_bank_select_out = data_bank_select;

	// ROM address: all eight window bits on top, so 16k is the ceiling
	assign rom_addr_out = {rom_window_select[WINDOW_KEEP_BITS-1:0],
		addr_in[OFFSET_BITS-1:0]}; // [R2] [R4]
	// Writes into the window are ignored: ROM is read-only
	assign rom_rd_out = ce_in && rd_in && region == REGION_WINDOW; // [R1]

	// Bank strobes gated by decoded target; unlisted codes reach nothing
	assign bank_addr_out = addr_in[OFFSET_BITS-1:0];
	assign bank_wdata_out = wdata_in;
	assign bank_page_out = bank.page;
	always_comb begin
		eeprom_rd_out = 1'b0;
		eeprom_wr_out = 1'b0;
		bank_ram_rd_out = 1'b0;
		bank_ram_wr_out = 1'b0;
		display_rd_out = 1'b0;
		display_wr_out = 1'b0;
		if (bank_access) begin
			case (bank.target)
				DSWBD_TGT_EEPROM: begin
					eeprom_rd_out = rd_in; // [R8]
					eeprom_wr_out = wr_in;
				end
				DSWBD_TGT_RAM: begin
					bank_ram_rd_out = rd_in; // [R10]
					bank_ram_wr_out = wr_in;
				end
				DSWBD_TGT_DISPLAY: begin
					display_rd_out = rd_in; // [R9]
					display_wr_out = wr_in;
				end
				default: begin
					eeprom_rd_out = 1'b0; // [R14]
				end
			endcase
		end
	end

	// Remember what a read addressed, for the data cycle after
	always_ff @(posedge mclk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rd_region <= REGION_REGS;
			rd_target <= DSWBD_TGT_NONE;
		end else if (ce_in && rd_in) begin
			rd_region <= region;
			rd_target <= bank.target;
		end else if (ce_in) begin
			rd_region <= REGION_REGS;
			rd_target <= DSWBD_TGT_NONE;
		end
	end

	// Read mux; write-only registers and other regs read as zero
	always_comb begin
		rdata_out = 8'h00;
		if (rd_region == REGION_WINDOW) begin
			rdata_out = rom_data_in; // [R1]
		end else if (rd_region == REGION_RAM) begin
			rdata_out = ram_rdata; // [R6]
		end else if (rd_region == REGION_BANK) begin
			case (rd_target)
				DSWBD_TGT_EEPROM: rdata_out = eeprom_data_in;
				DSWBD_TGT_RAM: rdata_out = bank_ram_data_in;
				DSWBD_TGT_DISPLAY: rdata_out = display_data_in;
				default: rdata_out = 8'h00; // [R14]
			endcase
		end
	end

	// Checks
	sequence s_win_write;
		ce_in && wr_in && addr_in == ADDR_ROM_WINDOW_SELECT;
	endsequence
	sequence s_win_read;
		ce_in && rd_in && addr_in[7:6] == REGION_WINDOW;
	endsequence

	chk_window_write_load: assert property (@(posedge mclk_in) // [R3]
		disable iff (!nrst_in)
		s_win_write |=> rom_window_select_out == $past(wdata_in))
		else $error("window register did not load");
	chk_window_rom_addr: assert property (@(posedge mclk_in) // [R2]
		disable iff (!nrst_in)
		s_win_read |-> rom_rd_out && rom_addr_out[5:0] == addr_in[5:0]
			&& rom_addr_out[13:6] == rom_window_select)
		else $error("window ROM address wrong");
	chk_window_16k_limit: assert property (@(posedge mclk_in) // [R4]
		disable iff (!nrst_in)
		s_win_read |-> rom_addr_out[13:12] == rom_window_select[7:6])
		else $error("top window bits lost from ROM address");
	chk_window_read_data: assert property (@(posedge mclk_in) // [R1]
		disable iff (!nrst_in)
		s_win_read ##1 1'b1 |-> rdata_out == rom_data_in)
		else $error("window read did not return ROM data");
	chk_static_ram_only: assert property (@(posedge mclk_in) // [R6]
		disable iff (!nrst_in)
		ram_access |-> !eeprom_wr_out && !bank_ram_wr_out
			&& !display_wr_out && !rom_rd_out)
		else $error("static RAM access leaked to another target");
	chk_bank_select_load: assert property (@(posedge mclk_in) // [R7]
		disable iff (!nrst_in)
		ce_in && wr_in && addr_in == ADDR_DATA_BANK_SELECT
			|=> data_bank_select_out == $past(wdata_in))
		else $error("bank select did not load");
	chk_eeprom_page_map: assert property (@(posedge mclk_in) // [R8]
		disable iff (!nrst_in)
		bank_access && wr_in && data_bank_select == CODE_EE5
			|-> eeprom_wr_out && bank_page_out == 3'h5)
		else $error("eeprom page 5 not selected");
	chk_display_page_map: assert property (@(posedge mclk_in) // [R9]
		disable iff (!nrst_in)
		bank_access && rd_in && data_bank_select == CODE_DISP6
			|-> display_rd_out && bank_page_out == 3'h6)
		else $error("display page 6 not selected");
	chk_ram_page_map: assert property (@(posedge mclk_in) // [R10]
		disable iff (!nrst_in)
		bank_access && wr_in && data_bank_select == CODE_RAM3
			|-> bank_ram_wr_out && bank_page_out == 3'h3)
		else $error("RAM page 3 not selected");
	chk_unlisted_no_write: assert property (@(posedge mclk_in) // [R14]
		disable iff (!nrst_in)
		bank.target == DSWBD_TGT_NONE |-> !eeprom_wr_out
			&& !bank_ram_wr_out && !display_wr_out)
		else $error("write reached memory with unlisted code");
	chk_window_reset_val: assert property (@(posedge mclk_in) // [R5]
		disable iff (!nrst_in)
		$rose(nrst_in) |-> rom_window_select_out == REG_RESET)
		else $error("window register reset value wrong");

	// Further sequences: bank reads and writes, register-area reads
	sequence s_bank_read;
		ce_in && rd_in && addr_in[7:6] == REGION_BANK;
	endsequence
	sequence s_bank_write;
		ce_in && wr_in && addr_in[7:6] == REGION_BANK;
	endsequence
	sequence s_regs_read;
		ce_in && rd_in && addr_in[7:6] == REGION_REGS;
	endsequence

	// ROM window is read-only and strobed only from 40h-7Fh
	chk_window_no_write: assert property (@(posedge mclk_in) // [R1]
		disable iff (!nrst_in)
		ce_in && wr_in && addr_in[7:6] == REGION_WINDOW |-> !rom_rd_out
			&& !eeprom_wr_out && !bank_ram_wr_out && !display_wr_out)
		else $error("write into ROM window reached a memory");
	chk_rom_strobe_source: assert property (@(posedge mclk_in) // [R1]
		disable iff (!nrst_in)
		rom_rd_out |-> ce_in && rd_in && addr_in[7:6] == REGION_WINDOW)
		else $error("ROM read strobe outside the window");
	// Bank codes against page and strobe, two each for eeprom and RAM, one for display
	chk_eeprom_page0_read: assert property (@(posedge mclk_in) // [R8]
		disable iff (!nrst_in)
		s_bank_read ##0 (data_bank_select == CODE_EE0)
			|-> eeprom_rd_out && bank_page_out == 3'h0)
		else $error("eeprom page 0 not selected");
	chk_eeprom_page3_read: assert property (@(posedge mclk_in) // [R8]
		disable iff (!nrst_in)
		s_bank_read ##0 (data_bank_select == CODE_EE3)
			|-> eeprom_rd_out && bank_page_out == 3'h3)
		else $error("eeprom page 3 not selected");
	chk_ram_page2_read: assert property (@(posedge mclk_in) // [R10]
		disable iff (!nrst_in)
		s_bank_read ##0 (data_bank_select == CODE_RAM2)
			|-> bank_ram_rd_out && !eeprom_rd_out
			&& bank_page_out == 3'h2)
		else $error("RAM page 2 not selected");
	chk_ram_page4_write: assert property (@(posedge mclk_in) // [R10]
		disable iff (!nrst_in)
		s_bank_write ##0 (data_bank_select == CODE_RAM4)
			|-> bank_ram_wr_out && !display_wr_out
			&& bank_page_out == 3'h4)
		else $error("RAM page 4 not written");
	chk_display_page5_write: assert property (@(posedge mclk_in) // [R9]
		disable iff (!nrst_in)
		s_bank_write ##0 (data_bank_select == CODE_DISP5)
			|-> display_wr_out && !eeprom_wr_out
			&& bank_page_out == 3'h5)
		else $error("display page 5 not written");
	chk_one_read_strobe: assert property (@(posedge mclk_in) // [R7]
		disable iff (!nrst_in)
		$onehot0({rom_rd_out, eeprom_rd_out, bank_ram_rd_out,
			display_rd_out}))
		else $error("more than one read strobe at once");
	chk_bank_strobe_region: assert property (@(posedge mclk_in) // [R7]
		disable iff (!nrst_in)
		eeprom_wr_out || bank_ram_wr_out || display_wr_out
			|-> ce_in && wr_in && addr_in[7:6] == REGION_BANK)
		else $error("bank write strobe outside the bank area");
	// Read data of the banked area in the cycle after
	chk_eeprom_read_data: assert property (@(posedge mclk_in) // [R8]
		disable iff (!nrst_in)
		s_bank_read ##0 eeprom_rd_out |=> rdata_out == eeprom_data_in)
		else $error("eeprom read data not returned");
	chk_display_read_data: assert property (@(posedge mclk_in) // [R9]
		disable iff (!nrst_in)
		s_bank_read ##0 display_rd_out |=> rdata_out == display_data_in)
		else $error("display read data not returned");
	chk_ram_bank_read_data: assert property (@(posedge mclk_in) // [R10]
		disable iff (!nrst_in)
		s_bank_read ##0 bank_ram_rd_out |=> rdata_out == bank_ram_data_in)
		else $error("bank RAM read data not returned");
	chk_unlisted_read_zero: assert property (@(posedge mclk_in) // [R14]
		disable iff (!nrst_in)
		s_bank_read ##0 (!eeprom_rd_out && !bank_ram_rd_out
			&& !display_rd_out) |=> rdata_out == 8'h00)
		else $error("unlisted bank code read not zero");
	chk_regs_read_zero: assert property (@(posedge mclk_in) // [R3]
		disable iff (!nrst_in)
		s_regs_read |=> rdata_out == 8'h00)
		else $error("write-only register read not zero");
	// Clock enable low freezes both registers
	chk_ce_freeze_regs: assert property (@(posedge mclk_in) // [R3] [R7]
		disable iff (!nrst_in)
		!ce_in |=> $stable(rom_window_select_out)
			&& $stable(data_bank_select_out))
		else $error("register changed while clock enable low");
endmodule : dswbd_decoder

// [shared/dswbd_pkg.sv]
// Constants for the data space window and bank decoder
package dswbd_pkg;
	localparam logic [7:0] ADDR_ROM_WINDOW_SELECT = 8'hC9;
	localparam logic [7:0] ADDR_DATA_BANK_SELECT = 8'hE8;
	localparam logic [1:0] REGION_BANK = 2'h0;
	localparam logic [1:0] REGION_WINDOW = 2'h1;
	localparam logic [1:0] REGION_RAM = 2'h2;
	localparam logic [1:0] REGION_REGS = 2'h3;
	localparam int OFFSET_BITS = 6;
	localparam int ROM_ADDR_BITS = 14;
	localparam int WINDOW_KEEP_BITS = 8;
	localparam int STATIC_RAM_BYTES = 64;
	localparam logic [7:0] CODE_EE0 = 8'h01;
	localparam logic [7:0] CODE_EE1 = 8'h02;
	localparam logic [7:0] CODE_EE2 = 8'h03;
	localparam logic [7:0] CODE_EE3 = 8'h81;
	localparam logic [7:0] CODE_EE4 = 8'h82;
	localparam logic [7:0] CODE_EE5 = 8'h83;
	localparam logic [7:0] CODE_RAM2 = 8'h04;
	localparam logic [7:0] CODE_RAM3 = 8'h08;
	localparam logic [7:0] CODE_RAM4 = 8'h10;
	localparam logic [7:0] CODE_DISP5 = 8'h20;
	localparam logic [7:0] CODE_DISP6 = 8'h40;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int EEPROM_PAGE_HIGH_BIT = 7;
	localparam int DISPLAY_PAGE6_BIT = 6;
	localparam int DISPLAY_PAGE5_BIT = 5;
	localparam int RAM_PAGE4_BIT = 4;
	localparam int RAM_PAGE3_BIT = 3;
	localparam int RAM_PAGE2_BIT = 2;
	typedef enum logic [1:0] {
		DSWBD_TGT_NONE,
		DSWBD_TGT_EEPROM,
		DSWBD_TGT_RAM,
		DSWBD_TGT_DISPLAY
	} dswbd_target_e;
endpackage : dswbd_pkg

// [shared/dswbd_bank_if.sv]
// Bank decode result passed between decoder modules
interface dswbd_bank_if;
	import dswbd_pkg::*;
	logic [7:0] code;
	dswbd_target_e target;
	logic [2:0] page;
	modport decoder (input code, output target, output page);
	modport user (output code, input target, input page);
endinterface : dswbd_bank_if

// [hdl/dswbd_bank_decode.sv]
// Combinational bank-select code decoder
module dswbd_bank_decode
	import dswbd_pkg::*;
(
	dswbd_bank_if.decoder bank
);
	// Only the listed one-hot or eeprom codes select a page
	always_comb begin
		bank.target = DSWBD_TGT_NONE;
		bank.page = 3'h0;
		case (bank.code)
			CODE_EE0: begin bank.target = DSWBD_TGT_EEPROM; bank.page = 3'h0; end // [R8]
			CODE_EE1: begin bank.target = DSWBD_TGT_EEPROM; bank.page = 3'h1; end // [R8]
			CODE_EE2: begin bank.target = DSWBD_TGT_EEPROM; bank.page = 3'h2; end // [R8]
			CODE_EE3: begin bank.target = DSWBD_TGT_EEPROM; bank.page = 3'h3; end // [R8]
			CODE_EE4: begin bank.target = DSWBD_TGT_EEPROM; bank.page = 3'h4; end // [R8]
			CODE_EE5: begin bank.target = DSWBD_TGT_EEPROM; bank.page = 3'h5; end // [R8]
			CODE_RAM2: begin bank.target = DSWBD_TGT_RAM; bank.page = 3'h2; end // [R10]
			CODE_RAM3: begin bank.target = DSWBD_TGT_RAM; bank.page = 3'h3; end // [R10]
			CODE_RAM4: begin bank.target = DSWBD_TGT_RAM; bank.page = 3'h4; end // [R10]
			CODE_DISP5: begin bank.target = DSWBD_TGT_DISPLAY; bank.page = 3'h5; end // [R9]
			CODE_DISP6: begin bank.target = DSWBD_TGT_DISPLAY; bank.page = 3'h6; end // [R9]
			default: begin bank.target = DSWBD_TGT_NONE; bank.page = 3'h0; end // [R14]
		endcase
	end
endmodule : dswbd_bank_decode

// [hdl/dswbd_static_ram.sv]
// Always-mapped 64-byte data RAM
module dswbd_static_ram
	import dswbd_pkg::*;
(
	input wire logic mclk_in,
	input wire logic ce_in,
	input wire logic wr_in,
	input wire logic [5:0] addr_in,
	input wire logic [7:0] wdata_in,
	output logic [7:0] rdata_out
);
	logic [7:0] mem [STATIC_RAM_BYTES];
	// Synchronous port; contents are not reset, like real RAM
	always_ff @(posedge mclk_in) begin
		if (ce_in) begin
			if (wr_in)
				mem[addr_in] <= wdata_in;
			rdata_out <= mem[addr_in];
		end
	end
endmodule : dswbd_static_ram

// [tb/dswbd_mem_model.sv]
// Far-side memory model answering the decoder's read strobes
module dswbd_mem_model
	import dswbd_pkg::*;
(
	input wire logic mclk_in,
	input wire logic [ROM_ADDR_BITS-1:0] rom_addr_in,
	input wire logic rom_rd_in,
	input wire logic [2:0] page_in,
	input wire logic [5:0] addr_in,
	input wire logic ee_rd_in,
	input wire logic ram_rd_in,
	input wire logic disp_rd_in,
	output logic [7:0] rom_data_out,
	output logic [7:0] ee_data_out,
	output logic [7:0] ram_data_out,
	output logic [7:0] disp_data_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rom_pat;
	initial begin
		rom_data_out = 8'h00;
		ee_data_out = 8'h00;
		ram_data_out = 8'h00;
		disp_data_out = 8'h00;
	end
	// Pattern mixes both window and offset bits
	assign rom_pat = rom_addr_in[7:0] ^ {2'h0, rom_addr_in[13:8]};
	// Data only the cycle after a strobe, else toggling junk
	always @(posedge mclk_in) begin
		rom_data_out <= rom_rd_in ? rom_pat : ~rom_data_out;
		ee_data_out <= ee_rd_in ? {2'h1, page_in, addr_in[2:0]} : ~ee_data_out;
		ram_data_out <= ram_rd_in ? {2'h2, page_in, addr_in[2:0]} : ~ram_data_out;
		disp_data_out <= disp_rd_in ? {2'h3, page_in, addr_in[2:0]} : ~disp_data_out;
	end
endmodule : dswbd_mem_model

// [tb/data_space_window_bank_decoder_bench.sv]
// Self-checking bench for the data space window and bank decoder
module data_space_window_bank_decoder_bench import dswbd_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic ce = 1'b1;
	logic [7:0] b_wdata;
	logic ee_wr, ram_wr, disp_wr;
	logic [7:0] rdata, win_q, bank_q, rom_d, ee_d, ram_d, disp_d;
	logic [13:0] rom_a;
	logic rom_rd, ee_rd, ram_rd, disp_rd;
	logic [5:0] b_addr;
	logic [2:0] page;
	int n_mismatch = 0;
	int comparisons = 0;
	// Clock enable drops only for the freeze check
	dswbd_decoder i_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .ce_in(ce),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .rom_addr_out(rom_a), .rom_rd_out(rom_rd),
		.rom_data_in(rom_d), .bank_addr_out(b_addr),
		.bank_wdata_out(b_wdata),
		.bank_page_out(page), .eeprom_rd_out(ee_rd), .eeprom_wr_out(ee_wr),
		.bank_ram_rd_out(ram_rd), .bank_ram_wr_out(ram_wr),
		.display_rd_out(disp_rd), .display_wr_out(disp_wr),
		.eeprom_data_in(ee_d), .bank_ram_data_in(ram_d),
		.display_data_in(disp_d), .rom_window_select_out(win_q),
		.data_bank_select_out(bank_q));
	dswbd_mem_model i_mem (.mclk_in(mclk_in), .rom_addr_in(rom_a),
		.rom_rd_in(rom_rd), .page_in(page), .addr_in(b_addr),
		.ee_rd_in(ee_rd), .ram_rd_in(ram_rd), .disp_rd_in(disp_rd),
		.rom_data_out(rom_d), .ee_data_out(ee_d), .ram_data_out(ram_d),
		.disp_data_out(disp_d));
	always #50 mclk_in = ~mclk_in;
	task automatic chk8(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8
	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk_in);
		wr <= 1'b0;
		#10; // Callers look only once the register has loaded
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [7:0] exp);
		@(posedge mclk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk_in);
		rd <= 1'b0;
		#10;
		chk8(what, exp, rdata);
	endtask : rd_chk
	// Bank write strobes are combinational, so look 10 ns after the edge
	task automatic wr_bank(input string what, input logic [1:0] kind,
		input logic [7:0] d);
		logic [2:0] want;
		case (kind)
			2'h1: want = 3'h4;
			2'h2: want = 3'h2;
			2'h3: want = 3'h1;
			default: want = 3'h0;
		endcase
		@(posedge mclk_in);
		addr <= 8'h05;
		wdata <= d;
		wr <= 1'b1;
		#10;
		chk8(what, {5'h00, want}, {5'h00, ee_wr, ram_wr, disp_wr});
		chk8("bank wdata", d, b_wdata);
		@(posedge mclk_in);
		wr <= 1'b0;
		#10;
	endtask : wr_bank
	function automatic logic [7:0] rom_exp(input logic [7:0] w,
		input logic [5:0] o);
		logic [13:0] a;
		a = {w, o};
		return a[7:0] ^ {2'h0, a[13:8]};
	endfunction : rom_exp
	task automatic t_reset();
		chk8("window reg", 8'h00, win_q);
		chk8("bank reg", 8'h00, bank_q);
		rd_chk("read C9h", 8'hC9, 8'h00);
		rd_chk("read E8h", 8'hE8, 8'h00);
		$display("test reset done");
	endtask : t_reset
	// All eight window bits reach the ROM address
	task automatic t_window();
		logic [7:0] ws [4];
		ws = '{8'h00, 8'h01, 8'h2A, 8'hFF};
		foreach (ws[i]) begin
			wr_reg(8'hBD, ws[i]);
			wr_reg(8'hC9, ws[i]);
			wr_reg(8'h45, 8'hFF);
			chk8("window reg", ws[i], win_q);
			rd_chk("rom 40h", 8'h40, rom_exp(ws[i], 6'h00));
			rd_chk("rom 7Fh", 8'h7F, rom_exp(ws[i], 6'h3F));
		end
		rd_chk("window copy", 8'hBD, 8'hFF);
		// A write with clock enable low must leave the window alone
		@(posedge mclk_in);
		ce <= 1'b0;
		wr_reg(8'hC9, 8'h12);
		@(posedge mclk_in);
		ce <= 1'b1;
		rd_chk("frozen window", 8'h7F, rom_exp(8'hFF, 6'h3F));
		chk8("frozen reg", 8'hFF, win_q);
		$display("test window done");
	endtask : t_window
	// Reset in mid-run clears both registers again
	task automatic t_rereset();
		wr_reg(8'hBE, CODE_RAM3);
		wr_reg(8'hE8, CODE_RAM3);
		@(posedge mclk_in);
		nrst_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		chk8("window in reset", 8'h00, win_q);
		nrst_in <= 1'b1;
		chk8("bank after reset", 8'h00, bank_q);
		rd_chk("rom after reset", 8'h40, rom_exp(8'h00, 6'h00));
		$display("test reset again done");
	endtask : t_rereset
	task automatic t_static();
		wr_reg(8'hE8, CODE_RAM2);
		wr_reg(8'h80, 8'hA5);
		wr_reg(8'hBF, 8'h5A);
		wr_reg(8'hE8, CODE_DISP5);
		rd_chk("ram 80h", 8'h80, 8'hA5);
		rd_chk("ram BFh", 8'hBF, 8'h5A);
		$display("test static ram done");
	endtask : t_static
	// Listed codes, then unlisted codes 80h and 00h
	task automatic t_banks();
		logic [7:0] cd [11];
		logic [1:0] tg [11];
		logic [2:0] pg [11];
		cd = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83, 8'h04, 8'h08,
			8'h10, 8'h20, 8'h40};
		tg = '{1, 1, 1, 1, 1, 1, 2, 2, 2, 3, 3};
		pg = '{0, 1, 2, 3, 4, 5, 2, 3, 4, 5, 6};
		foreach (cd[i]) begin
			wr_reg(8'hBE, cd[i]);
			wr_reg(8'hE8, cd[i]);
			chk8("bank reg", cd[i], bank_q);
			chk8("bank page", {5'h00, pg[i]}, {5'h00, page});
			rd_chk("bank 05h", 8'h05, {tg[i], pg[i], 3'h5});
			wr_bank("bank strobe", tg[i], cd[i]);
			rd_chk("bank copy", 8'hBE, cd[i]);
		end
		wr_reg(8'hE8, 8'h80);
		rd_chk("code 80h", 8'h05, 8'h00);
		wr_bank("code 80h strobe", 2'h0, 8'h77);
		wr_reg(8'hE8, 8'h00);
		rd_chk("no bank", 8'h3F, 8'h00);
		$display("test banks done");
	endtask : t_banks
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	initial begin
		repeat (5) @(posedge mclk_in);
		nrst_in <= 1'b1;
		t_reset();
		t_window();
		t_rereset();
		t_static();
		t_banks();
		conclude();
	end
endmodule : data_space_window_bank_decoder_bench
